// File: include/urb_bridge_consts.vh
/*
 * Constants of the serial register access bridge: marker bytes,
 * frame lengths, field widths and reset levels.
 * Assumes the including file uses them in declarations and logic only.
 */
`ifndef URB_BRIDGE_CONSTS_VH
`define URB_BRIDGE_CONSTS_VH

// Clock and link defaults
`define URB_CLK_FREQ    250000000
`define URB_BAUD        115200
`define URB_CNT_W       16

// Marker and command bytes
`define URB_CMD_READ    8'h0A
`define URB_MARK_START  8'h0B
`define URB_MARK_END    8'h0C

// Field widths
`define URB_KEY_W       4
`define URB_TOG_W       4
`define URB_IND_W       4
`define URB_GA_W        10
`define URB_GB_W        16
`define URB_GC_W        32
`define URB_GD_W        40
`define URB_PAD_W       7

// Packed frame sizes
`define URB_SNAP_W      120
`define URB_STAGE_W     112
`define URB_RD_BYTES    4'hF
`define URB_WR_BYTES    4'hE
`define URB_BYTE_W      8
`define URB_BIT_LAST    3'h7
`define URB_TX_BITS     4'hA

// Levels and reset values
`define URB_RST_BIT     1'b0
`define URB_LINE_IDLE   1'b1
`define URB_START_BIT   1'b0

// Output buffer shape
`define URB_FIFO_DEPTH  16
`define URB_FIFO_AW     4

`endif

// File: src/urb_bridge.v
/*
 * Serial register access bridge with its transmit buffer.
 * Assumes 8N1 framing, one clock, inputs synchronous except SERIAL_RX.
 */
//Function
//- Clock rate and baud are parameters
//- Clock, reset, serial in, serial out
//- Serial receive input synchronised internally
//- Read samples all ports in one cycle
//- Snapshot is sent back over serial
//- Write loads all outputs in one cycle
//- Write always carries every output value
//- Write staged, outputs change after end
//- Inputs are never affected by writes
//- Each port has width, outputs registered
`timescale 1ns/10ps
`default_nettype none
`include "urb_bridge_consts.vh"

////////////////////////////////////////////////////////////////////////
// Byte buffer between the reply builder and the transmitter
module urb_fifo #(
	parameter WIDTH = `URB_BYTE_W,
	parameter DEPTH = `URB_FIFO_DEPTH,
	parameter AW    = `URB_FIFO_AW
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst_n,
	// Fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];   // Storage
	reg  [AW:0]      wr_ptr_r;          // Write pointer, wrap bit on top
	reg  [AW:0]      rd_ptr_r;          // Read pointer, wrap bit on top
	wire             full;
	wire             empty;

	// Full when indices match and wrap bits differ
	assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
		(wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign empty     = (wr_ptr_r == rd_ptr_r);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_ptr_r[AW-1:0]];

	// Storage write
	always @(posedge clk)
	begin
		if (in_valid && !full)
			mem[wr_ptr_r[AW-1:0]] <= in_data;
	end

	// Pointer update
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_r <= {(AW+1){`URB_RST_BIT}};
			rd_ptr_r <= {(AW+1){`URB_RST_BIT}};
		end
		else
		begin
			if (in_valid && !full)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (out_ready && !empty)
				rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////
// Bridge top: serial link, command handling, register ports
module urb_bridge #(
	parameter CLOCK_FREQUENCY_PARAM = `URB_CLK_FREQ,
	parameter BAUD_RATE             = `URB_BAUD
) (
	// Clock and reset
	input  wire                  SYS_CLK,
	input  wire                  RESET_N,
	// Serial link
	input  wire                  SERIAL_RX,
	output wire                  SERIAL_TX,
	// Sampled inputs
	input  wire [`URB_KEY_W-1:0] BUTTON_INPUTS,
	input  wire [`URB_TOG_W-1:0] SWITCH_INPUTS,
	// Host written outputs
	output reg  [`URB_IND_W-1:0] INDICATOR_OUTPUTS,
	output reg                   RGB_RED_OUTPUT,
	output reg                   RGB_GREEN_OUTPUT,
	output reg                   RGB_BLUE_OUTPUT,
	output reg  [`URB_GA_W-1:0]  GENERAL_OUTPUT_A,
	output reg  [`URB_GB_W-1:0]  GENERAL_OUTPUT_B,
	output reg  [`URB_GC_W-1:0]  GENERAL_OUTPUT_C,
	output reg  [`URB_GD_W-1:0]  GENERAL_OUTPUT_D
);
	// Cycles per bit and per half bit
	// Quotient must fit the timer width; cut to it on purpose
	localparam integer          BIT_QUO  = CLOCK_FREQUENCY_PARAM / BAUD_RATE;
	localparam [`URB_CNT_W-1:0] BIT_CYC  = BIT_QUO[`URB_CNT_W-1:0];
	localparam [`URB_CNT_W-1:0] HALF_CYC = BIT_CYC >> 1;

	// Receiver states
	localparam [3:0] RX_IDLE  = 4'h1;
	localparam [3:0] RX_START = 4'h2;
	localparam [3:0] RX_DATA  = 4'h4;
	localparam [3:0] RX_STOP  = 4'h8;

	// Command states
	localparam [5:0] C_IDLE   = 6'h01;
	localparam [5:0] C_WDATA  = 6'h02;
	localparam [5:0] C_WEND   = 6'h04;
	localparam [5:0] C_RSTART = 6'h08;
	localparam [5:0] C_RDATA  = 6'h10;
	localparam [5:0] C_REND   = 6'h20;

	reg                      rst_meta_r;   // Reset release stage 1
	reg                      rst_n_r;      // Reset used by the design
	reg                      rx_meta_r;    // Receive sync stage 1
	reg                      rx_s_r;       // Synchronised receive level
	reg  [3:0]               rx_st_r;      // Receiver state
	reg  [`URB_CNT_W-1:0]    rx_cnt_r;     // Receiver bit timer
	reg  [2:0]               rx_bit_r;     // Receiver bit index
	reg  [`URB_BYTE_W-1:0]   rx_sh_r;      // Receiver shift register
	reg                      rx_vld_r;     // Received byte pulse
	reg  [5:0]               c_st_r;       // Command state
	reg  [3:0]               c_cnt_r;      // Byte counter
	reg  [`URB_SNAP_W-1:0]   snap_r;       // Read snapshot
	reg  [`URB_STAGE_W-1:0]  stage_r;      // Write staging
	reg  [`URB_BYTE_W-1:0]   push_data;    // Byte offered to buffer
	reg                      push_vld;     // Offer strobe
	wire                     push_rdy;     // Buffer has room
	wire                     push_go;      // Byte accepted
	wire                     tx_vld;       // Buffer holds a byte
	wire [`URB_BYTE_W-1:0]   tx_data;      // Byte at buffer head
	wire                     tx_take;      // Transmitter takes byte
	reg  [`URB_TX_BITS-1:0]  tx_sh_r;      // Transmit shift register
	reg  [3:0]               tx_left_r;    // Bits still to send
	reg  [`URB_CNT_W-1:0]    tx_cnt_r;     // Transmit bit timer
	wire                     tx_tick;      // Bit end enable pulse
	wire [`URB_PAD_W-1:0]    pad;          // Fill of packed frames
	wire                     last_byte;    // Counter at frame end

	// Timer step: reload at zero, else count down
	function [`URB_CNT_W-1:0] tmr_next;
		input [`URB_CNT_W-1:0] cnt;
		input [`URB_CNT_W-1:0] reload;
		begin
			if (cnt == {`URB_CNT_W{`URB_RST_BIT}})
				tmr_next = reload;
			else
				tmr_next = cnt - 1'b1;
		end
	endfunction

	assign pad = {`URB_PAD_W{`URB_RST_BIT}};

	////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops
	always @(posedge SYS_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			rst_meta_r <= `URB_RST_BIT;
			rst_n_r    <= `URB_RST_BIT;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Receive input synchroniser
	always @(posedge SYS_CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			rx_meta_r <= `URB_LINE_IDLE;
			rx_s_r    <= `URB_LINE_IDLE;
		end
		else
		begin
			rx_meta_r <= SERIAL_RX;
			rx_s_r    <= rx_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Byte receiver, samples mid bit
	always @(posedge SYS_CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			rx_st_r  <= RX_IDLE;
			rx_cnt_r <= {`URB_CNT_W{`URB_RST_BIT}};
			rx_bit_r <= 3'h0;
			rx_sh_r  <= {`URB_BYTE_W{`URB_RST_BIT}};
			rx_vld_r <= `URB_RST_BIT;
		end
		else
		begin
			rx_vld_r <= `URB_RST_BIT;
			rx_cnt_r <= tmr_next(rx_cnt_r, BIT_CYC - 1'b1);
			case (rx_st_r)
			RX_IDLE:
				// Low level on the synchronised line opens a frame
				if (rx_s_r == `URB_START_BIT)
				begin
					rx_cnt_r <= HALF_CYC;
					rx_st_r  <= RX_START;
				end
			RX_START:
				// Start bit must still be low mid bit
				if (rx_cnt_r == {`URB_CNT_W{`URB_RST_BIT}})
				begin
					rx_bit_r <= 3'h0;
					rx_st_r  <= (rx_s_r == `URB_START_BIT) ?
						RX_DATA : RX_IDLE;
				end
			RX_DATA:
				// Bits arrive least significant first
				if (rx_cnt_r == {`URB_CNT_W{`URB_RST_BIT}})
				begin
					rx_sh_r  <= {rx_s_r, rx_sh_r[`URB_BYTE_W-1:1]};
					rx_bit_r <= rx_bit_r + 1'b1;
					if (rx_bit_r == `URB_BIT_LAST)
						rx_st_r <= RX_STOP;
				end
			RX_STOP:
				// Framing error drops the byte
				if (rx_cnt_r == {`URB_CNT_W{`URB_RST_BIT}})
				begin
					rx_vld_r <= (rx_s_r == `URB_LINE_IDLE);
					rx_st_r  <= RX_IDLE;
				end
			default:
				rx_st_r <= RX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Command handling, snapshot and staged write
	assign last_byte = (c_st_r == C_RDATA) ?
		(c_cnt_r == `URB_RD_BYTES - 1'b1) :
		(c_cnt_r == `URB_WR_BYTES - 1'b1);
	assign push_go = push_vld && push_rdy;

	always @(posedge SYS_CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			c_st_r            <= C_IDLE;
			c_cnt_r           <= 4'h0;
			snap_r            <= {`URB_SNAP_W{`URB_RST_BIT}};
			stage_r           <= {`URB_STAGE_W{`URB_RST_BIT}};
			INDICATOR_OUTPUTS <= {`URB_IND_W{`URB_RST_BIT}};
			RGB_RED_OUTPUT    <= `URB_RST_BIT;
			RGB_GREEN_OUTPUT  <= `URB_RST_BIT;
			RGB_BLUE_OUTPUT   <= `URB_RST_BIT;
			GENERAL_OUTPUT_A  <= {`URB_GA_W{`URB_RST_BIT}};
			GENERAL_OUTPUT_B  <= {`URB_GB_W{`URB_RST_BIT}};
			GENERAL_OUTPUT_C  <= {`URB_GC_W{`URB_RST_BIT}};
			GENERAL_OUTPUT_D  <= {`URB_GD_W{`URB_RST_BIT}};
		end
		else
		begin
			case (c_st_r)
			C_IDLE:
				if (rx_vld_r && rx_sh_r == `URB_CMD_READ)
				begin
					// One-cycle capture of every port
					snap_r <= {pad, BUTTON_INPUTS, SWITCH_INPUTS,
						INDICATOR_OUTPUTS, RGB_RED_OUTPUT,
						RGB_GREEN_OUTPUT, RGB_BLUE_OUTPUT,
						GENERAL_OUTPUT_A, GENERAL_OUTPUT_B,
						GENERAL_OUTPUT_C, GENERAL_OUTPUT_D};
					c_st_r <= C_RSTART;
				end
				else if (rx_vld_r && rx_sh_r == `URB_MARK_START)
				begin
					c_cnt_r <= 4'h0;
					c_st_r  <= C_WDATA;
				end
			C_WDATA:
				// Shift bytes into staging, outputs untouched
				if (rx_vld_r)
				begin
					stage_r <= {stage_r[`URB_STAGE_W-`URB_BYTE_W-1:0],
						rx_sh_r};
					c_cnt_r <= c_cnt_r + 1'b1;
					if (last_byte)
						c_st_r <= C_WEND;
				end
			C_WEND:
				if (rx_vld_r)
				begin
					// Only a closing marker commits
					if (rx_sh_r == `URB_MARK_END)
						{INDICATOR_OUTPUTS, RGB_RED_OUTPUT,
						RGB_GREEN_OUTPUT, RGB_BLUE_OUTPUT,
						GENERAL_OUTPUT_A, GENERAL_OUTPUT_B,
						GENERAL_OUTPUT_C, GENERAL_OUTPUT_D} <=
						stage_r[`URB_STAGE_W-`URB_PAD_W-1:0];
					c_st_r <= C_IDLE;
				end
			C_RSTART:
				if (push_go)
				begin
					c_cnt_r <= 4'h0;
					c_st_r  <= C_RDATA;
				end
			C_RDATA:
				// Most significant byte first
				if (push_go)
				begin
					snap_r  <= snap_r << `URB_BYTE_W;
					c_cnt_r <= c_cnt_r + 1'b1;
					if (last_byte)
						c_st_r <= C_REND;
				end
			C_REND:
				if (push_go)
					c_st_r <= C_IDLE;
			default:
				c_st_r <= C_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Reply byte select
	always @*
	begin
		push_vld  = 1'b1;
		push_data = `URB_MARK_END;
		case (c_st_r)
		C_RSTART:
			push_data = `URB_MARK_START;
		C_RDATA:
			push_data = snap_r[`URB_SNAP_W-1:`URB_SNAP_W-`URB_BYTE_W];
		C_REND:
			push_data = `URB_MARK_END;
		default:
			push_vld = 1'b0;
		endcase
	end

	// Reply buffer; a full buffer stalls the reply builder
	urb_fifo #(
		.WIDTH (`URB_BYTE_W),
		.DEPTH (`URB_FIFO_DEPTH),
		.AW    (`URB_FIFO_AW)
	) u_fifo (
		.clk       (SYS_CLK),
		.rst_n     (rst_n_r),
		.in_valid  (push_vld),
		.in_ready  (push_rdy),
		.in_data   (push_data),
		.out_valid (tx_vld),
		.out_ready (tx_take),
		.out_data  (tx_data)
	);

	////////////////////////////////////////////////////////////////////
	// Byte transmitter, 8N1
	assign tx_take   = tx_vld && (tx_left_r == 4'h0);
	assign tx_tick   = (tx_left_r != 4'h0) &&
		(tx_cnt_r == {`URB_CNT_W{`URB_RST_BIT}});
	assign SERIAL_TX = tx_sh_r[0];

	always @(posedge SYS_CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			tx_sh_r   <= {`URB_TX_BITS{`URB_LINE_IDLE}};
			tx_left_r <= 4'h0;
			tx_cnt_r  <= {`URB_CNT_W{`URB_RST_BIT}};
		end
		else if (tx_take)
		begin
			// Load stop, data, start
			tx_sh_r   <= {`URB_LINE_IDLE, tx_data, `URB_START_BIT};
			tx_left_r <= `URB_TX_BITS;
			tx_cnt_r  <= BIT_CYC - 1'b1;
		end
		else if (tx_left_r != 4'h0)
		begin
			tx_cnt_r <= tmr_next(tx_cnt_r, BIT_CYC - 1'b1);
			if (tx_tick)
			begin
				tx_sh_r   <= {`URB_LINE_IDLE,
					tx_sh_r[`URB_TX_BITS-1:1]};
				tx_left_r <= tx_left_r - 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

// File: dv/urb_bridge_asserts.sv
/*
 * Port checker for the serial register bridge.
 * Assumes 8N1 framing and an active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module urb_bridge_asserts #(
	parameter CLOCK_FREQUENCY_PARAM = 250000000,
	parameter BAUD_RATE             = 115200
) (
	// Clock and reset
	input wire logic        SYS_CLK,
	input wire logic        RESET_N,
	// Serial link
	input wire logic        SERIAL_RX,
	input wire logic        SERIAL_TX,
	// Sampled inputs
	input wire logic [3:0]  BUTTON_INPUTS,
	input wire logic [3:0]  SWITCH_INPUTS,
	// Written outputs
	input wire logic [3:0]  INDICATOR_OUTPUTS,
	input wire logic        RGB_RED_OUTPUT,
	input wire logic        RGB_GREEN_OUTPUT,
	input wire logic        RGB_BLUE_OUTPUT,
	input wire logic [9:0]  GENERAL_OUTPUT_A,
	input wire logic [15:0] GENERAL_OUTPUT_B,
	input wire logic [31:0] GENERAL_OUTPUT_C,
	input wire logic [39:0] GENERAL_OUTPUT_D
);
	localparam int BIT = CLOCK_FREQUENCY_PARAM / BAUD_RATE;
	wire [104:0] outs = {INDICATOR_OUTPUTS, RGB_RED_OUTPUT,
		RGB_GREEN_OUTPUT, RGB_BLUE_OUTPUT, GENERAL_OUTPUT_A,
		GENERAL_OUTPUT_B, GENERAL_OUTPUT_C, GENERAL_OUTPUT_D};
	logic tx_q;  // Last transmit level
	int   run_r; // Length of the current level run

	////////////////////////////////////////////////////////////////
	// Run length of the transmit line
	always @(posedge SYS_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			tx_q <= 1'b1;
			run_r <= 0;
		end
		else
		begin
			tx_q <= SERIAL_TX;
			run_r <= (SERIAL_TX != tx_q) ? 1 : run_r + 1;
		end
	end

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);

	////////////////////////////////////////////////////////////////
	// Assertions
	a_idle_after_rst: assert property ($rose(RESET_N) |-> SERIAL_TX [*8])
		else $error("transmit line not idle after reset");
	a_outs_zero_rst: assert property ($rose(RESET_N) |-> outs == 105'h0)
		else $error("outputs not cleared by reset");
	a_commit_after_stop: assert property ($changed(outs) |-> $past(SERIAL_RX, 4))
		else $error("outputs changed outside a stop bit");
	a_commit_spacing: assert property ($changed(outs) |=> $stable(outs) [*8])
		else $error("outputs changed in two nearby cycles");
	a_tx_start_low: assert property ($fell(SERIAL_TX) |-> !SERIAL_TX [*8])
		else $error("transmit low run too short");
	a_tx_stop_high: assert property ($rose(SERIAL_TX) |-> SERIAL_TX [*8])
		else $error("transmit high run too short");
	a_tx_low_grid: assert property (SERIAL_TX && !tx_q |-> run_r % BIT == 0)
		else $error("transmit low run off the bit grid");
	a_reply_after_cmd: assert property (!SERIAL_TX && tx_q && run_r > BIT
		|-> $past(SERIAL_RX, 7))
		else $error("reply began away from a command stop bit");

	// Main scenarios
	c_commit: cover property ($changed(outs));
	c_reply: cover property (!SERIAL_TX && tx_q && run_r > BIT);
	c_reset: cover property ($rose(RESET_N));
endmodule

bind urb_bridge urb_bridge_asserts #(
	.CLOCK_FREQUENCY_PARAM(CLOCK_FREQUENCY_PARAM),
	.BAUD_RATE(BAUD_RATE)
) i_chk (
	.SYS_CLK(SYS_CLK),
	.RESET_N(RESET_N),
	.SERIAL_RX(SERIAL_RX),
	.SERIAL_TX(SERIAL_TX),
	.BUTTON_INPUTS(BUTTON_INPUTS),
	.SWITCH_INPUTS(SWITCH_INPUTS),
	.INDICATOR_OUTPUTS(INDICATOR_OUTPUTS),
	.RGB_RED_OUTPUT(RGB_RED_OUTPUT),
	.RGB_GREEN_OUTPUT(RGB_GREEN_OUTPUT),
	.RGB_BLUE_OUTPUT(RGB_BLUE_OUTPUT),
	.GENERAL_OUTPUT_A(GENERAL_OUTPUT_A),
	.GENERAL_OUTPUT_B(GENERAL_OUTPUT_B),
	.GENERAL_OUTPUT_C(GENERAL_OUTPUT_C),
	.GENERAL_OUTPUT_D(GENERAL_OUTPUT_D)
);
`default_nettype wire

// File: dv/urb_host.sv
/*
 * Host model: sends commands and frames, collects replies, 8N1.
 * Assumes BIT clock cycles per serial bit.
 */
`timescale 1ns/10ps
`default_nettype none
module urb_host #(
	parameter BIT = 16
) (
	// Clock
	input wire logic clk,
	// Serial lines
	output logic     tx,
	input wire logic rx
);
	initial tx = 1'b1; // Line idles high

	////////////////////////////////////////////////////////////////
	// One byte out, start bit, LSB first, stop bit
	task send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			tx <= f[i];
			repeat (BIT) @(posedge clk);
		end
	endtask

	// One byte in, sampled mid-bit, bounded wait for start
	task recv_byte(output logic [7:0] b);
		int n;
		n = 0;
		while (rx && n < 5000)
		begin
			@(posedge clk);
			n++;
		end
		repeat (BIT / 2) @(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT) @(posedge clk);
			b[i] = rx;
		end
		repeat (BIT) @(posedge clk);
	endtask

	// Read command and the whole reply
	task read_all(output logic [135:0] r);
		logic [7:0] b;
		fork
			send_byte(8'h0A);
			for (int k = 16; k >= 0; k--)
			begin
				recv_byte(b);
				r[k*8 +: 8] = b;
			end
		join
	endtask

	// Write frame without its end marker, all values MSB byte first
	task send_head(input logic [111:0] v);
		send_byte(8'h0B);
		for (int k = 13; k >= 0; k--)
			send_byte(v[k*8 +: 8]);
	endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
/*
 * Testbench of the serial register bridge: reads, staged writes,
 * a malformed frame and a read-modify-write.
 * Assumes a bit time of 16 clocks from the chosen clock parameter.
 */
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic         sys_clk;
	logic         reset_n;
	wire          rx_line;
	wire          tx_line;
	logic [3:0]   buttons;  // Driven push-button levels
	logic [3:0]   switches; // Driven switch levels
	wire  [104:0] outs;     // All written outputs packed
	logic [104:0] m;        // Expected outputs
	logic [135:0] r;        // Reply bytes
	logic [111:0] w;        // Write vector
	int           error_cnt;
	int           checks_done;

	// Baud left at its default
	urb_bridge #(.CLOCK_FREQUENCY_PARAM(1843200)) i_dut (
		.SYS_CLK(sys_clk),
		.RESET_N(reset_n),
		.SERIAL_RX(rx_line),
		.SERIAL_TX(tx_line),
		.BUTTON_INPUTS(buttons),
		.SWITCH_INPUTS(switches),
		.INDICATOR_OUTPUTS(outs[104:101]),
		.RGB_RED_OUTPUT(outs[100]),
		.RGB_GREEN_OUTPUT(outs[99]),
		.RGB_BLUE_OUTPUT(outs[98]),
		.GENERAL_OUTPUT_A(outs[97:88]),
		.GENERAL_OUTPUT_B(outs[87:72]),
		.GENERAL_OUTPUT_C(outs[71:40]),
		.GENERAL_OUTPUT_D(outs[39:0])
	);
	urb_host #(.BIT(16)) i_host (
		.clk(sys_clk),
		.tx(rx_line),
		.rx(tx_line)
	);

	////////////////////////////////////////////////////////////////
	// Compare and count
	task chk(input logic [135:0] seen, input logic [135:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask

	task tally_and_finish();
		if (error_cnt == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Full read against inputs and expected outputs
	task rd_chk();
		i_host.read_all(r);
		chk(r, {8'h0B, 7'h00, buttons, switches, m, 8'h0C});
	endtask

	// Write, outputs held until the end marker
	task wr(input logic [111:0] v, input logic [7:0] last);
		i_host.send_head(v);
		chk(outs, m);
		i_host.send_byte(last);
		if (last === 8'h0C)
			m = v[104:0];
		chk(outs, m);
	endtask

	////////////////////////////////////////////////////////////////
	// Clock
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Main sequence
	initial
	begin
		reset_n = 1'b0;
		buttons = 4'h0;
		switches = 4'h0;
		m = 105'h0;
		error_cnt = 0;
		checks_done = 0;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk(outs, 136'h0);
		buttons <= 4'hA;
		switches <= 4'h5;
		rd_chk();
		// Marker values inside data, pad bits set
		w = {7'h55, 4'hA, 3'h5, 10'h30C, 16'h0B0A, 32'h0C0B0A5A,
			40'hF00DBEEF0A};
		wr(w, 8'h0C);
		rd_chk();
		wr(~w, 8'h0D);
		// Stray end marker while idle must be ignored
		i_host.send_byte(8'h0C);
		rd_chk();
		buttons <= 4'h5;
		switches <= 4'hA;
		// Read-back that the partial update reuses is checked too
		rd_chk();
		w = {7'h00, r[112:8]};
		w[71:40] = 32'h12345678;
		wr(w, 8'h0C);
		rd_chk();
		tally_and_finish();
	end

	// Watchdog
	initial
	begin
		repeat (60000) @(posedge sys_clk);
		error_cnt++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
